// *** testbench/testbench.sv ***
// Self-checking bench for the conditional-negate execution slice
`timescale 1ns/1ps
module testbench;
	import cneg_pkg::*;
	logic        sys_clk_i;
	logic        rst_i;
	logic        start_i;
	logic        cond_true_i;
	instr_t      instr_i;
	logic [31:0] src_data_i;
	logic [8:0]  src_addr_o;
	reg_write_t  wr_o;
	logic        flag_z_o;
	logic        flag_c_o;
	logic        ready_o;
	logic        busy_o;
	logic        done_o;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          cycles = 0;
	logic        z_m;
	logic        c_m;
	logic        got_en;
	logic [8:0]  got_addr;
	logic [31:0] got_data;

	conditional_negate_alu u_conditional_negate_alu (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .start_i(start_i), .instr_i(instr_i),
		.cond_true_i(cond_true_i), .src_data_i(src_data_i), .src_addr_o(src_addr_o),
		.wr_o(wr_o), .flag_z_o(flag_z_o), .flag_c_o(flag_c_o), .ready_o(ready_o),
		.busy_o(busy_o), .done_o(done_o)
	);

	// 200 MHz system clock
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt++;
			summarize();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	// One instruction; fx is {zero effect, carry effect, write result, immediate}
	task automatic run(input logic [5:0] op, input logic [3:0] fx, input logic [3:0] cond,
			input logic [8:0] src, input logic [31:0] data, input logic ok);
		logic [31:0] opnd;
		logic        exec;
		int          n;
		opnd = fx[0] ? {23'h0, src} : data;
		exec = (cond == COND_ALWAYS || (cond != COND_NEVER && ok)) && (op inside {OP_NEG_NC, OP_NEG_NZ, OP_NEG_Z});
		start_i = 1'b1;
		instr_i = '{op, fx[3], fx[2], fx[1], fx[0], cond, 9'h155, src};
		cond_true_i = ok;
		src_data_i = data;
		@(posedge sys_clk_i);
		#1;
		start_i = 1'b0;
		check(src_addr_o, src);
		check({busy_o, ready_o}, 2'b10);
		n = 0;
		while (done_o !== 1'b1 && n < 8) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		check(64'(n), 64'd4);
		got_en = wr_o.en;
		got_addr = wr_o.addr;
		got_data = wr_o.data;
		// Flag model follows the source operand, not the result
		if (exec && fx[3])
			z_m = (opnd == 32'h0000_0000);
		if (exec && fx[2])
			c_m = opnd[31];
		check(flag_z_o, z_m);
		check(flag_c_o, c_m);
	endtask : run

	// Both flags to f through effect-only instructions with no write
	task automatic set_flags(input logic f);
		run(OP_NEG_NC, 4'b1000, COND_ALWAYS, 9'h000, f ? 32'h0 : 32'h1, 1'b0);
		run(OP_NEG_NC, 4'b0100, COND_ALWAYS, 9'h000, f ? 32'h8000_0000 : 32'h0, 1'b0);
		check(got_en, 1'b0);
	endtask : set_flags

	// Every opcode, both flag states, the boundary sources
	task automatic t_table();
		logic [31:0] srcs[6];
		logic [5:0]  ops[3];
		logic [31:0] exp;
		logic        neg;
		srcs = '{32'hffff_ffff, 32'h0, 32'h1, 32'h7fff_ffff, 32'h8000_0000, 32'h8000_0001};
		ops = '{OP_NEG_NC, OP_NEG_NZ, OP_NEG_Z};
		foreach (ops[i]) begin
			for (int f = 0; f < 2; f++) begin
				foreach (srcs[k]) begin
					set_flags(f[0]);
					run(ops[i], 4'b1110, COND_ALWAYS, 9'h0a3, srcs[k], 1'b0);
					neg = (ops[i] == OP_NEG_Z) ? f[0] : !f[0];
					exp = neg ? (~srcs[k] + 32'h1) : srcs[k];
					check(got_en, 1'b1);
					check(got_addr, 9'h155);
					if (ops[i] == OP_NEG_NC)
						check(got_data, exp);
					else if (ops[i] == OP_NEG_NZ)
						check(got_data, exp);
					else
						check(got_data, exp);
					if (srcs[k] == 32'h8000_0000)
						check({got_data, flag_z_o, flag_c_o}, {32'h8000_0000, 2'b01});
				end
			end
		end
		$display("table test done");
	endtask : t_table

	// Immediate literal replaces the register read and is zero-extended
	task automatic t_imm();
		set_flags(1'b0);
		run(OP_NEG_NZ, 4'b1111, COND_ALWAYS, 9'h1ff, 32'hdead_beef, 1'b0);
		check(got_data, 32'hffff_fe01);
		check({flag_z_o, flag_c_o}, 2'b00);
		$display("immediate test done");
	endtask : t_imm

	// Never condition and a failed outside condition both act as no-ops
	task automatic t_never();
		set_flags(1'b1);
		run(OP_NEG_Z, 4'b1110, COND_NEVER, 9'h000, 32'h0000_0001, 1'b1);
		check(got_en, 1'b0);
		check({flag_z_o, flag_c_o}, 2'b11);
		run(OP_NEG_NC, 4'b1110, 4'h3, 9'h000, 32'h0000_0001, 1'b0);
		check(got_en, 1'b0);
		run(OP_NEG_NC, 4'b0010, 4'h3, 9'h000, 32'h0000_0001, 1'b1);
		check({got_en, got_data}, {1'b1, 32'h0000_0001});
		// Opcode outside this slice acts as a no-operation
		run(6'h29, 4'b1110, COND_ALWAYS, 9'h000, 32'h0000_0001, 1'b1);
		check({got_en, flag_z_o, flag_c_o}, 3'b011);
		$display("no-operation test done");
	endtask : t_never

	// Reset, then the scenarios in turn
	initial begin
		rst_i = 1'b1;
		start_i = 1'b0;
		instr_i = '0;
		cond_true_i = 1'b0;
		src_data_i = 32'h0;
		z_m = 1'b0;
		c_m = 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		rst_i = 1'b0;
		check({ready_o, busy_o, done_o, flag_z_o, flag_c_o}, 5'b10000);
		t_table();
		t_imm();
		t_never();
		summarize();
	end
endmodule : testbench

// *** verilog/cneg_pkg.sv ***
// Shared constants and types for the conditional-negate datapath slice
package cneg_pkg;

	localparam int          DATA_W        = 32;
	localparam int          ADDR_W        = 9;
	localparam int          INSTR_CLOCKS  = 4;

	// Opcodes handled by this slice
	localparam logic [5:0]  OP_NEG_NC     = 6'h2d;
	localparam logic [5:0]  OP_NEG_NZ     = 6'h2f;
	localparam logic [5:0]  OP_NEG_Z      = 6'h2e;

	// Condition field codes
	localparam logic [3:0]  COND_NEVER    = 4'h0;
	localparam logic [3:0]  COND_ALWAYS   = 4'hf;

	// Reset values
	localparam logic        FLAG_RST      = 1'h0;
	localparam logic [31:0] DATA_RST      = 32'h0000_0000;
	localparam logic [8:0]  ADDR_RST      = 9'h000;

	// Instruction word, most significant field first
	typedef struct packed {
		logic [5:0] opcode;
		logic       write_zero_flag_effect;
		logic       write_carry_flag_effect;
		logic       write_result;
		logic       imm;
		logic [3:0] cond;
		logic [8:0] dest;
		logic [8:0] src;
	} instr_t;

	// Destination register write port
	typedef struct packed {
		logic        en;
		logic [8:0]  addr;
		logic [31:0] data;
	} reg_write_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_FETCH = 3'h1,
		ST_READ  = 3'h3,
		ST_EXEC  = 3'h2,
		ST_WRITE = 3'h6
	} state_t;

endpackage : cneg_pkg

// *** verilog/cond_negate_unit.sv ***
// Combinational conditional-negate core with flag results
`timescale 1ns/1ps
module cond_negate_unit
	import cneg_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic [5:0]   opcode_i,
	input  wire logic [W-1:0] operand_i,
	input  wire logic         zero_flag_i,
	input  wire logic         carry_flag_i,
	output logic      [W-1:0] result_o,
	output logic              zero_o,
	output logic              carry_o
);
	logic         negate;
	logic [W-1:0] negated;

	// Choose negation from opcode and current flag
	assign negate = ((opcode_i == OP_NEG_NC) && !carry_flag_i)
	             || ((opcode_i == OP_NEG_NZ) && !zero_flag_i)
	             || ((opcode_i == OP_NEG_Z) && zero_flag_i);

	// Two's complement wraps, so the most negative value maps to itself
	assign negated  = ~operand_i + {{(W-1){1'b0}}, 1'b1};
	assign result_o = negate ? negated : operand_i;

	// Flags judge the source operand, not the result
	assign zero_o  = (operand_i == '0);
	assign carry_o = operand_i[W-1];

endmodule : cond_negate_unit

// *** verilog/conditional_negate_alu.sv ***
// Four-clock execution slice for the conditional-negate instructions
`timescale 1ns/1ps
module conditional_negate_alu
	import cneg_pkg::*;
(
	input  wire logic                sys_clk_i,
	input  wire logic                rst_i,
	input  wire logic                start_i,
	input  cneg_pkg::instr_t         instr_i,
	input  wire logic                cond_true_i,
	input  wire logic [31:0]         src_data_i,
	output logic      [8:0]          src_addr_o,
	output cneg_pkg::reg_write_t     wr_o,
	output logic                     flag_z_o,
	output logic                     flag_c_o,
	output logic                     ready_o,
	output logic                     busy_o,
	output logic                     done_o
);
	state_t      state_q, state_d;
	instr_t      instr_q;
	logic        exec_q;
	logic [31:0] op_q, res_q;
	logic        rz_q, rc_q, z_used_q, c_used_q;
	reg_write_t  wr_q;
	logic        z_q, c_q, done_q, busy_q, ready_q;
	logic [8:0]  addr_q;

	wire logic        accept;
	wire logic        cond_ok;
	wire logic        op_ok;
	wire logic [31:0] operand_sel;
	wire logic [31:0] unit_res;
	wire logic        unit_z;
	wire logic        unit_c;

	// Start taken when idle or in the last clock, giving one instruction per four
	assign accept = start_i && ((state_q == ST_IDLE) || (state_q == ST_WRITE));

	// Never suppresses all, Always passes all; other codes come from the outside decoder
	assign cond_ok = (instr_i.cond == COND_ALWAYS)
	              || ((instr_i.cond != COND_NEVER) && cond_true_i);
	assign op_ok   = (instr_i.opcode == OP_NEG_NC) || (instr_i.opcode == OP_NEG_NZ)
	              || (instr_i.opcode == OP_NEG_Z);

	// Immediate literal widened with zeros
	assign operand_sel = instr_q.imm ? {23'h000000, instr_q.src} : src_data_i;

	cond_negate_unit #(
		.W(DATA_W)
	) u_neg (
		.opcode_i     (instr_q.opcode),
		.operand_i    (op_q),
		.zero_flag_i  (z_q),
		.carry_flag_i (c_q),
		.result_o     (unit_res),
		.zero_o       (unit_z),
		.carry_o      (unit_c)
	);

	// Fixed four-state walk regardless of operand source
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:  state_d = accept ? ST_FETCH : ST_IDLE;
			ST_FETCH: state_d = ST_READ;
			ST_READ:  state_d = ST_EXEC;
			ST_EXEC:  state_d = ST_WRITE;
			ST_WRITE: state_d = accept ? ST_FETCH : ST_IDLE;
			default:  state_d = ST_IDLE;
		endcase
	end

	// Sequencer and status outputs
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			busy_q  <= 1'b0;
			ready_q <= 1'b1;
		end else begin
			state_q <= state_d;
			busy_q  <= (state_d != ST_IDLE);
			ready_q <= (state_d == ST_IDLE) || (state_d == ST_WRITE);
		end
	end

	// Capture instruction and decide once whether it executes
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			instr_q <= '0;
			exec_q  <= 1'b0;
			addr_q  <= ADDR_RST;
		end else if (accept) begin
			instr_q <= instr_i;
			exec_q  <= cond_ok && op_ok;
			addr_q  <= instr_i.src;
		end
	end

	// Register file answers the source address during the fetch clock
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			op_q <= DATA_RST;
		end else if (state_q == ST_FETCH) begin
			op_q <= operand_sel;
		end
	end

	// Compute result and flag candidates; flags cannot move in between
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			res_q    <= DATA_RST;
			rz_q     <= FLAG_RST;
			rc_q     <= FLAG_RST;
			z_used_q <= FLAG_RST;
			c_used_q <= FLAG_RST;
		end else if (state_q == ST_READ) begin
			res_q    <= unit_res;
			rz_q     <= unit_z;
			rc_q     <= unit_c;
			z_used_q <= z_q;
			c_used_q <= c_q;
		end
	end

	// Commit in the last clock; each effect bit acts on its own
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wr_q   <= '0;
			z_q    <= FLAG_RST;
			c_q    <= FLAG_RST;
			done_q <= 1'b0;
		end else begin
			done_q <= (state_q == ST_WRITE);
			wr_q   <= '0;
			if ((state_q == ST_WRITE) && exec_q) begin
				wr_q.en   <= instr_q.write_result;
				wr_q.addr <= instr_q.dest;
				wr_q.data <= res_q;
				if (instr_q.write_zero_flag_effect) begin
					z_q <= rz_q;
				end
				if (instr_q.write_carry_flag_effect) begin
					c_q <= rc_q;
				end
			end
		end
	end

	assign src_addr_o = addr_q;
	assign wr_o       = wr_q;
	assign flag_z_o   = z_q;
	assign flag_c_o   = c_q;
	assign ready_o    = ready_q;
	assign busy_o     = busy_q;
	assign done_o     = done_q;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	// Commit-time copy, so checks survive a back-to-back accept in the last clock
	instr_t chk_instr_q;
	logic   chk_exec_q;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			chk_instr_q <= '0;
			chk_exec_q  <= 1'b0;
		end else if (state_q == ST_WRITE) begin
			chk_instr_q <= instr_q;
			chk_exec_q  <= exec_q;
		end
	end

	wire logic [5:0] cur_op = chk_instr_q.opcode;

	AST_NEG_NC: assert property (done_o && wr_o.en && cur_op == OP_NEG_NC |->
		wr_o.data == (c_used_q ? op_q : 32'h0 - op_q)) else $error("carry-clear negate wrong");
	AST_NEG_NZ: assert property (done_o && wr_o.en && cur_op == OP_NEG_NZ |->
		wr_o.data == (z_used_q ? op_q : 32'h0 - op_q)) else $error("zero-clear negate wrong");
	AST_NEG_Z: assert property (done_o && wr_o.en && cur_op == OP_NEG_Z |->
		wr_o.data == (z_used_q ? 32'h0 - op_q : op_q)) else $error("zero negate wrong");
	AST_OPERAND: assert property (state_q == ST_READ |->
		op_q == (instr_q.imm ? {23'h000000, instr_q.src} : $past(src_data_i))) else $error("operand wrong");
	AST_ZFLAG: assert property (done_o && chk_exec_q && chk_instr_q.write_zero_flag_effect |->
		flag_z_o == (op_q == 32'h0)) else $error("zero flag wrong");
	AST_CFLAG: assert property (done_o && chk_exec_q && chk_instr_q.write_carry_flag_effect |->
		flag_c_o == op_q[31]) else $error("carry flag wrong");
	AST_MIN_NEG: assert property (done_o && wr_o.en && op_q == 32'h8000_0000 |->
		wr_o.data == 32'h8000_0000) else $error("most negative value wrong");
	AST_NO_RESULT: assert property (done_o && !chk_instr_q.write_result |-> !wr_o.en)
		else $error("suppressed result written");

	sequence s_never_taken;
		accept && (instr_i.cond == COND_NEVER);
	endsequence
	sequence s_quiet_finish;
		!wr_o.en && $stable(flag_z_o) && $stable(flag_c_o) && done_o;
	endsequence
	AST_NEVER_NOP: assert property (s_never_taken |-> ##5 s_quiet_finish)
		else $error("never-condition instruction had an effect");
	// First busy clock may still show the previous done pulse when starts run back to back
	AST_FOUR_CLOCKS: assert property (accept |-> ##1 busy_o ##1 (busy_o && !done_o) [*3] ##1 done_o)
		else $error("instruction not four clocks");
	AST_DONE_PULSE: assert property (done_o |=> !done_o)
		else $error("done held longer than one clock");
	AST_NR_CARRY: assert property (done_o && chk_exec_q && !chk_instr_q.write_result
		&& chk_instr_q.write_carry_flag_effect |-> !wr_o.en && flag_c_o == op_q[31])
		else $error("effects not independent");

endmodule : conditional_negate_alu
